// *** hdl/rxvm_pkg.sv ***
// Shared constants and types for the receive-port channel map and line statistics block.
package rxvm_pkg;

  // ----------------------------------------------------------------
  // Port count and register offsets
  // ----------------------------------------------------------------
  localparam int        NUM_PORTS   = 4;
  localparam logic [7:0] ADDR_RAW10  = 8'h70;
  localparam logic [7:0] ADDR_RAW12  = 8'h71;
  localparam logic [7:0] ADDR_REMAP  = 8'h72;
  localparam logic [7:0] ADDR_LINES_HI = 8'h73;
  localparam logic [7:0] ADDR_LINES_LO = 8'h74;
  localparam logic [7:0] ADDR_LEN_HI = 8'h75;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CHAN_LSB     = 6;
  localparam int         CHAN_MSB     = 7;
  localparam int         TYPE_LSB     = 0;
  localparam int         TYPE_MSB     = 5;
  localparam logic [5:0] RAW10_TYPE_RST = 6'h2b;
  localparam logic [5:0] RAW12_TYPE_RST = 6'h2c;
  localparam logic [7:0] REMAP_RST    = 8'he4;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [15:0] STAT_RST    = 16'h0000;
  localparam logic [15:0] STAT_MAX    = 16'hffff;
  localparam logic [15:0] STAT_ONE    = 16'h0001;

  // ----------------------------------------------------------------
  // Strapped input mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CSI      = 2'h0;
  localparam logic [1:0] MODE_RAW12_LF = 2'h1;
  localparam logic [1:0] MODE_RAW12_HF = 2'h2;
  localparam logic [1:0] MODE_RAW10    = 2'h3;

  // ----------------------------------------------------------------
  // Per-port state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  raw10Channel;
    logic [5:0]  raw10Type;
    logic [1:0]  raw12Channel;
    logic [5:0]  raw12Type;
    logic [7:0]  channelRemap;
    logic [1:0]  portInputMode;
    logic        fvPrev;
    logic        lvPrev;
    logic [15:0] lineCnt;
    logic [15:0] lenCnt;
    logic [15:0] lastLen;
    logic [15:0] frameLines;
    logic [15:0] lineLength;
    logic [7:0]  frameLinesLower;
    logic [7:0]  lineLengthLower;
    logic        linesLock;
    logic        lenLock;
    logic        linesHiRead;
    logic        lenHiRead;
  } rxvm_port_t;

endpackage

// *** hdl/rxvm_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module rxvm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstSync_b,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
  } rxvm_fifo_state_t;

  rxvm_fifo_state_t st;
  rxvm_fifo_state_t next_st;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  // Full and empty come straight from the count, so a stalled drain side backs up the source.
  assign inReady  = rstSync_b && (st.count != DEPTH_CNT); // Refused while held in reset.
  assign outValid = (st.count != '0);
  assign outData  = st.mem[st.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer and count update.
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr = (st.wrPtr == LAST_PTR) ? '0 : st.wrPtr + 1'b1;
    end
    if (pop) begin
      next_st.rdPtr = (st.rdPtr == LAST_PTR) ? '0 : st.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// *** hdl/rxvm_port_regs.sv ***
// Per-port channel tagging, channel remap and frame line statistics with their registers.
// How it works
// - Each receive port has its own register copy, chosen by the port select.
// - Raw10 mode tags packets with channel bits 7:6, default the port number.
// - Raw10 mode uses data type bits 5:0, reset 0x2B, for emitted packets.
// - Raw10 settings apply only in raw10 mode, ignored otherwise.
// - Raw12 mode tags packets with channel bits 7:6, default the port number.
// - Raw12 mode uses data type bits 5:0, reset 0x2C, for emitted packets.
// - Raw12 settings apply in either raw12 mode, low or high frequency.
// - Incoming channel n is replaced by remap bits [2n+1:2n]; reset 0xE4 is identity.
// - Remapping applies only in the serial packet input mode.
// - Lines per frame are counted; last frame's count shown as high and low bytes.
// - With its change enable set, the line count holds until software reads it.
// - Reading the line count high byte captures the matching low byte.
// - Line length of the last frame is reported, namely its last line.
// - With its change enable set, the line length holds until software reads it.
// - Upper line length byte is read-only and resets to zero.
// - Input mode is a two-bit strap: 00 packets, 01/10 raw12, 11 raw10.
// - Reading the line length high byte captures the matching low byte.
`timescale 1ns/1ps
`default_nettype none
module rxvm_port_regs #(
  parameter int DATA_W     = 32,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rst_b,
  // Register access, already routed by the serial control port
  input  wire logic [1:0]                      portSelect,
  input  wire logic [7:0]                      regAddr,
  input  wire logic                            regWr,
  input  wire logic [7:0]                      regWrData,
  input  wire logic                            regRd,
  output logic [7:0]                           regRdData,
  // Low line length byte, served by the neighbouring register
  input  wire logic                            lineLengthLowerRd,
  output logic [7:0]                           lineLengthLower,
  // Loose control bits and straps, one per port
  input  wire logic [rxvm_pkg::NUM_PORTS-1:0]   lineTotalChangeIrqEn,
  input  wire logic [rxvm_pkg::NUM_PORTS-1:0]   lineLengthChangeIrqEn,
  input  wire logic [2*rxvm_pkg::NUM_PORTS-1:0] portInputModeStrap,
  // Video framing from the link receivers
  input  wire logic [rxvm_pkg::NUM_PORTS-1:0]   frameValid,
  input  wire logic [rxvm_pkg::NUM_PORTS-1:0]   lineValid,
  // Incoming packet headers and data
  input  wire logic                            inValid,
  output logic                                 inReady,
  input  wire logic [1:0]                      inPort,
  input  wire logic [1:0]                      inChannel,
  input  wire logic [5:0]                      inType,
  input  wire logic [DATA_W-1:0]               inData,
  // Tagged packets toward the transmitter
  output logic                                 outValid,
  input  wire logic                            outReady,
  output logic [1:0]                           outPort,
  output logic [1:0]                           outChannel,
  output logic [5:0]                           outType,
  output logic [DATA_W-1:0]                    outData
);

  localparam int NP = rxvm_pkg::NUM_PORTS;
  localparam int PKT_W = 2 + 2 + 6 + DATA_W;

  typedef struct packed {
    rxvm_pkg::rxvm_port_t [NP-1:0] port;
    logic [2*NP-1:0]              strap1;
    logic [2*NP-1:0]              strap2;
    logic [2*NP-1:0]              strap3;
    logic                         strapTaken;
    logic [2:0]                   strapFill;
    logic [7:0]                   rdData;
  } rxvm_state_t;

  // Reset image: channel fields default to the port's own number.
  function automatic rxvm_state_t resetImage();
    rxvm_state_t r;
    r = '0;
    for (int p = 0; p < NP; p++) begin
      r.port[p].raw10Channel = 2'(p);
      r.port[p].raw10Type    = rxvm_pkg::RAW10_TYPE_RST;
      r.port[p].raw12Channel = 2'(p);
      r.port[p].raw12Type    = rxvm_pkg::RAW12_TYPE_RST;
      r.port[p].channelRemap = rxvm_pkg::REMAP_RST;
    end
    return r;
  endfunction

  localparam rxvm_state_t RESET_IMAGE = resetImage();

  rxvm_state_t       st;
  rxvm_state_t       next_st;
  logic [1:0]        rstSync;
  logic              rstSync_b;
  logic [1:0]        tagChannel;
  logic [5:0]        tagType;
  logic [PKT_W-1:0]  fifoIn;
  logic [PKT_W-1:0]  fifoOut;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Two flops so that every other flop leaves reset on the same clean edge.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSync_b = rstSync[1];

  // ----------------------------------------------------------------
  // Packet tagging
  // ----------------------------------------------------------------
  // The mode of the packet's own port decides which fields tag it.
  always_comb begin
    tagChannel = st.port[inPort].channelRemap[{inChannel, 1'b0} +: 2];
    tagType    = inType;
    case (st.port[inPort].portInputMode)
      rxvm_pkg::MODE_CSI: begin
        tagChannel = st.port[inPort].channelRemap[{inChannel, 1'b0} +: 2];
        tagType    = inType;
      end
      rxvm_pkg::MODE_RAW12_LF, rxvm_pkg::MODE_RAW12_HF: begin
        tagChannel = st.port[inPort].raw12Channel;
        tagType    = st.port[inPort].raw12Type;
      end
      rxvm_pkg::MODE_RAW10: begin
        tagChannel = st.port[inPort].raw10Channel;
        tagType    = st.port[inPort].raw10Type;
      end
      default: begin
        tagChannel = inChannel;
        tagType    = inType;
      end
    endcase
  end

  assign fifoIn = {inPort, tagChannel, tagType, inData};

  // Four words of slack absorb short stalls of the transmitter without dropping packets.
  rxvm_fifo #(
    .WIDTH (PKT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstSync_b (rstSync_b),
    .inValid   (inValid),
    .inReady   (inReady),
    .inData    (fifoIn),
    .outValid  (outValid),
    .outReady  (outReady),
    .outData   (fifoOut)
  );

  assign {outPort, outChannel, outType, outData} = fifoOut;

  // ----------------------------------------------------------------
  // Registers, straps and frame measurement
  // ----------------------------------------------------------------
  always_comb begin
    logic fv;
    logic lv;
    logic lvRise;
    logic lvFall;
    logic fvRise;
    logic fvFall;
    logic sel;
    logic linesHiRd;
    logic linesLoRd;
    logic lenHiRd;
    logic lenLoRd;
    logic linesRelease;
    logic lenRelease;
    logic linesUpdate;
    logic lenUpdate;
    fv = 1'b0;
    lv = 1'b0;
    lvRise = 1'b0;
    lvFall = 1'b0;
    fvRise = 1'b0;
    fvFall = 1'b0;
    sel = 1'b0;
    linesHiRd = 1'b0;
    linesLoRd = 1'b0;
    lenHiRd = 1'b0;
    lenLoRd = 1'b0;
    linesRelease = 1'b0;
    lenRelease = 1'b0;
    linesUpdate = 1'b0;
    lenUpdate = 1'b0;
    next_st = st;

    next_st.strap1 = portInputModeStrap;
    next_st.strap2 = st.strap1;
    next_st.strap3 = st.strap2;
    // Reset zeros in the stages must not pass for a strapped value, so wait until all three are filled.
    next_st.strapFill = {st.strapFill[1:0], 1'b1};
    if (!st.strapTaken && st.strapFill[2] && (st.strap2 == st.strap3)) begin
      next_st.strapTaken = 1'b1;
      for (int p = 0; p < NP; p++) begin
        next_st.port[p].portInputMode = st.strap3[2*p +: 2];
      end
    end

    if (regRd) begin
      case (regAddr)
        rxvm_pkg::ADDR_RAW10: next_st.rdData = {st.port[portSelect].raw10Channel, st.port[portSelect].raw10Type};
        rxvm_pkg::ADDR_RAW12: next_st.rdData = {st.port[portSelect].raw12Channel, st.port[portSelect].raw12Type};
        rxvm_pkg::ADDR_REMAP: next_st.rdData = st.port[portSelect].channelRemap;
        rxvm_pkg::ADDR_LINES_HI: next_st.rdData = st.port[portSelect].frameLines[15:8];
        rxvm_pkg::ADDR_LINES_LO: next_st.rdData = st.port[portSelect].frameLinesLower;
        rxvm_pkg::ADDR_LEN_HI: next_st.rdData = st.port[portSelect].lineLength[15:8];
        default: next_st.rdData = rxvm_pkg::BYTE_RST;
      endcase
    end

    for (int p = 0; p < NP; p++) begin
      sel = (portSelect == 2'(p));
      // writes reach only the selected copy
      if (regWr && sel) begin
        case (regAddr)
          rxvm_pkg::ADDR_RAW10: begin
            next_st.port[p].raw10Channel = regWrData[rxvm_pkg::CHAN_MSB:rxvm_pkg::CHAN_LSB];
            next_st.port[p].raw10Type    = regWrData[rxvm_pkg::TYPE_MSB:rxvm_pkg::TYPE_LSB];
          end
          rxvm_pkg::ADDR_RAW12: begin
            next_st.port[p].raw12Channel = regWrData[rxvm_pkg::CHAN_MSB:rxvm_pkg::CHAN_LSB];
            next_st.port[p].raw12Type    = regWrData[rxvm_pkg::TYPE_MSB:rxvm_pkg::TYPE_LSB];
          end
          rxvm_pkg::ADDR_REMAP: next_st.port[p].channelRemap = regWrData;
          default: begin
          end
        endcase
      end

      // Edges of the framing levels; these come from logic on this clock.
      fv = frameValid[p];
      lv = lineValid[p];
      lvRise = lv && !st.port[p].lvPrev;
      lvFall = !lv && st.port[p].lvPrev;
      fvRise = fv && !st.port[p].fvPrev;
      fvFall = !fv && st.port[p].fvPrev;
      next_st.port[p].fvPrev = fv;
      next_st.port[p].lvPrev = lv;

      if (fvRise) begin
        next_st.port[p].lineCnt = lvRise ? rxvm_pkg::STAT_ONE : rxvm_pkg::STAT_RST;
      end else if (fv && lvRise && (st.port[p].lineCnt != rxvm_pkg::STAT_MAX)) begin
        next_st.port[p].lineCnt = st.port[p].lineCnt + rxvm_pkg::STAT_ONE;
      end
      // length of each line in cycles
      if (lvRise) begin
        next_st.port[p].lenCnt = rxvm_pkg::STAT_ONE;
      end else if (lv && (st.port[p].lenCnt != rxvm_pkg::STAT_MAX)) begin
        next_st.port[p].lenCnt = st.port[p].lenCnt + rxvm_pkg::STAT_ONE;
      end
      if (lvFall) begin
        next_st.port[p].lastLen = st.port[p].lenCnt;
      end

      // Read side effects on the selected copy.
      linesHiRd = regRd && sel && (regAddr == rxvm_pkg::ADDR_LINES_HI);
      linesLoRd = regRd && sel && (regAddr == rxvm_pkg::ADDR_LINES_LO);
      lenHiRd   = regRd && sel && (regAddr == rxvm_pkg::ADDR_LEN_HI);
      lenLoRd   = lineLengthLowerRd && sel;
      // both bytes read releases the hold
      linesRelease = linesLoRd && st.port[p].linesHiRead;
      lenRelease   = lenLoRd && st.port[p].lenHiRead;

      // held line count waits for its read
      linesUpdate = fvFall && (!lineTotalChangeIrqEn[p] || !st.port[p].linesLock || linesRelease);
      // held line length waits for its read
      lenUpdate   = fvFall && (!lineLengthChangeIrqEn[p] || !st.port[p].lenLock || lenRelease);

      // capture low byte on high read
      if (linesHiRd) begin
        next_st.port[p].frameLinesLower = st.port[p].frameLines[7:0];
        next_st.port[p].linesHiRead     = 1'b1;
      end else if (linesLoRd) begin
        next_st.port[p].linesHiRead = 1'b0;
      end
      // capture low length byte on high read
      if (lenHiRd) begin
        next_st.port[p].lineLengthLower = st.port[p].lineLength[7:0];
        next_st.port[p].lenHiRead       = 1'b1;
      end else if (lenLoRd) begin
        next_st.port[p].lenHiRead = 1'b0;
      end

      // A new frame result taken in the release cycle re-arms the hold, so set beats clear.
      if (linesUpdate) begin
        next_st.port[p].frameLines = st.port[p].lineCnt;
        next_st.port[p].linesLock  = lineTotalChangeIrqEn[p];
      end else if (linesRelease) begin
        next_st.port[p].linesLock = 1'b0;
      end
      // last line of the frame wins
      if (lenUpdate) begin
        next_st.port[p].lineLength = lvFall ? st.port[p].lenCnt : st.port[p].lastLen;
        next_st.port[p].lenLock    = lineLengthChangeIrqEn[p];
      end else if (lenRelease) begin
        next_st.port[p].lenLock = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st <= RESET_IMAGE;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData       = st.rdData;
  assign lineLengthLower = st.port[portSelect].lineLengthLower;

endmodule
`default_nettype wire

// *** tb/rxvm_video_src.sv ***
// Behavioural remote video source that frames lines toward one receive port.
`timescale 1ns/1ps
`default_nettype none
module rxvm_video_src (
  // Clock
  input  wire logic        mclk,
  // Frame request: go is a one-cycle pulse from the bench; the bench holds the other inputs for the whole frame
  input  wire logic        go,
  input  wire logic [1:0]  port,
  input  wire logic [7:0]  lines,
  input  wire logic [15:0] lineLen,
  input  wire logic [15:0] lastLen,
  // Framing toward the receiver
  output logic [3:0]       frameValid,
  output logic [3:0]       lineValid,
  output logic             busy
);
  int i;

  // Framing idles low between frames.
  initial begin
    frameValid = 4'h0;
    lineValid = 4'h0;
    busy = 1'b0;
  end

  // One frame per request; the last line may differ in length from the rest.
  always begin
    @(posedge mclk);
    if (go) begin
      busy <= 1'b1;
      frameValid[port] <= 1'b1;
      for (i = 0; i < lines; i++) begin
        lineValid[port] <= 1'b1;
        repeat ((i == lines - 1) ? lastLen : lineLen) @(posedge mclk);
        lineValid[port] <= 1'b0;
        repeat (2) @(posedge mclk);
      end
      frameValid[port] <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/rxvm_port_regs_checker.sv ***
// Port-level assertions for the channel map and line statistics block.
`timescale 1ns/1ps
`default_nettype none
module rxvm_port_regs_checker #(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // Register access
  input  wire logic [1:0]        portSelect,
  input  wire logic [7:0]        regAddr,
  input  wire logic              regWr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regRd,
  input  wire logic [7:0]        regRdData,
  input  wire logic [7:0]        lineLengthLower,
  // Packet stream
  input  wire logic              inValid,
  input  wire logic              inReady,
  input  wire logic [1:0]        inPort,
  input  wire logic [DATA_W-1:0] inData,
  input  wire logic              outValid,
  input  wire logic              outReady,
  input  wire logic [1:0]        outPort,
  input  wire logic [1:0]        outChannel,
  input  wire logic [5:0]        outType,
  input  wire logic [DATA_W-1:0] outData
);
  logic       push;
  logic       pop;
  logic [2:0] fill;

  // Shadow fill level, so refusals can be judged without looking inside.
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fill <= 3'h0;
    end else begin
      fill <= fill + {2'h0, push} - {2'h0, pop};
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence cfgWrite;
    regWr && regAddr >= 8'h70 && regAddr <= 8'h72;
  endsequence
  sequence sameRead;
    regRd && !regWr && $stable(regAddr) && $stable(portSelect);
  endsequence

  chk_write_read_back: assert property (cfgWrite ##1 !regWr ##1 sameRead |=> regRdData == $past(regWrData, 3))
    else $error("config register did not read back");
  chk_unmapped_zero: assert property (regRd && (regAddr < 8'h70 || regAddr > 8'h75) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_read_data_hold: assert property (!regRd |=> $stable(regRdData))
    else $error("read data moved without a read");
  chk_len_low_capture: assert property (!(regRd && regAddr == 8'h75) ##1 $stable(portSelect) |-> $stable(lineLengthLower))
    else $error("low length byte moved without a high byte read");
  chk_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(outPort)
                                 && $stable(outChannel) && $stable(outType))
    else $error("output word changed while stalled");
  chk_valid_fill: assert property (outValid == (fill != 3'h0))
    else $error("output valid disagrees with fill level");
  chk_full_refuse: assert property (fill == 3'h4 |-> !inReady)
    else $error("ready while four words held");
  chk_fifo_pass: assert property (push && fill == 3'h0 |=> outValid && outData == $past(inData)
                                  && outPort == $past(inPort))
    else $error("word did not reach empty output next cycle");
endmodule
`default_nettype wire

// *** tb/rxvm_port_regs_bench.sv ***
// Self-checking bench for the channel map and line statistics block.
`timescale 1ns/1ps
`default_nettype none
module rxvm_port_regs_bench;
  logic mclk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, lineLengthLowerRd = 1'b0;
  logic [1:0] portSelect = 2'h0, inPort = 2'h0, inChannel = 2'h0, vPort = 2'h0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, vLines = 8'h00;
  logic [3:0] cntEn = 4'h0, lenEn = 4'h0;
  logic inValid = 1'b0, outReady = 1'b0, go = 1'b0;
  logic [5:0] inType = 6'h00;
  logic [31:0] inData = 32'h0;
  logic [15:0] vLen = 16'h0, vLast = 16'h0;
  logic [7:0] regRdData, lineLengthLower;
  logic [3:0] frameValid, lineValid;
  logic inReady, outValid, vBusy;
  logic [1:0] outPort, outChannel;
  logic [5:0] outType;
  logic [31:0] outData;
  logic [41:0] expQ [$];
  int errTotal = 0;
  int nTests = 0;
  int p;
  int c;

  // Ten nanosecond clock.
  always #5 mclk = ~mclk;

  // Ports 0..3 strapped as packet, raw12 low, raw12 high and raw10 input.
  rxvm_port_regs i_rxvm_port_regs (.mclk(mclk), .rst_b(rst_b), .portSelect(portSelect), .regAddr(regAddr),
    .regWr(regWr), .regWrData(regWrData), .regRd(regRd), .regRdData(regRdData),
    .lineLengthLowerRd(lineLengthLowerRd), .lineLengthLower(lineLengthLower), .lineTotalChangeIrqEn(cntEn),
    .lineLengthChangeIrqEn(lenEn), .portInputModeStrap(8'he4), .frameValid(frameValid), .lineValid(lineValid),
    .inValid(inValid), .inReady(inReady), .inPort(inPort), .inChannel(inChannel), .inType(inType),
    .inData(inData), .outValid(outValid), .outReady(outReady), .outPort(outPort), .outChannel(outChannel),
    .outType(outType), .outData(outData));
  rxvm_video_src i_rxvm_video_src (.mclk(mclk), .go(go), .port(vPort), .lines(vLines), .lineLen(vLen),
    .lastLen(vLast), .frameValid(frameValid), .lineValid(lineValid), .busy(vBusy));

  task automatic check(input logic [41:0] seen, input logic [41:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic testDone();
    if (errTotal == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input int pt, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    portSelect <= 2'(pt);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read data lands on the edge that takes the strobe.
  task automatic rdc(input int pt, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    portSelect <= 2'(pt);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 check({34'h0, regRdData}, {34'h0, exp});
  endtask

  // Packet ports follow the remap, raw ports take the rewritten identifier registers.
  function automatic logic [41:0] tagOf(input int pt, input int ch, input logic [31:0] d);
    logic [1:0] vc;
    logic [5:0] ty;
    vc = 2'(3 - ch);
    ty = 6'h1e;
    if (pt == 1 || pt == 2) begin
      vc = 2'h1;
      ty = 6'h10 | 6'(pt);
    end
    if (pt == 3) begin
      vc = 2'h2;
      ty = 6'h13;
    end
    return {2'(pt), vc, ty, d};
  endfunction

  task automatic push(input int pt, input int ch);
    int t;
    @(posedge mclk);
    inValid <= 1'b1;
    inPort <= 2'(pt);
    inChannel <= 2'(ch);
    inType <= 6'h1e;
    inData <= 32'hc0de0000 | 32'(pt * 4 + ch);
    expQ.push_back(tagOf(pt, ch, 32'hc0de0000 | 32'(pt * 4 + ch)));
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (!inReady && t < 50);
    if (!inReady) begin
      errTotal++;
      testDone();
    end
    inValid <= 1'b0;
  endtask

  // The drain side stalls a cycle before taking each word.
  task automatic pop();
    int t;
    t = 0;
    #1;
    while (!outValid && t < 50) begin
      @(posedge mclk);
      #1 t++;
    end
    if (!outValid) begin
      errTotal++;
      testDone();
    end
    check({outPort, outChannel, outType, outData}, expQ.pop_front());
    @(posedge mclk);
    outReady <= 1'b1;
    @(posedge mclk);
    outReady <= 1'b0;
  endtask

  task automatic frame(input int pt, input int n, input int len, input int last);
    int t;
    @(posedge mclk);
    go <= 1'b1;
    vPort <= 2'(pt);
    vLines <= 8'(n);
    vLen <= 16'(len);
    vLast <= 16'(last);
    @(posedge mclk);
    go <= 1'b0;
    t = 0;
    do begin
      @(posedge mclk);
      #1 t++;
    end while (vBusy && t < 5000);
    if (vBusy) begin
      errTotal++;
      testDone();
    end
  endtask

  // High byte first; the low length byte is then acknowledged as read.
  task automatic stats(input int pt, input logic [15:0] n, input logic [15:0] len);
    rdc(pt, 8'h73, n[15:8]);
    rdc(pt, 8'h74, n[7:0]);
    rdc(pt, 8'h75, len[15:8]);
    check({34'h0, lineLengthLower}, {34'h0, len[7:0]});
    @(posedge mclk);
    lineLengthLowerRd <= 1'b1;
    @(posedge mclk);
    lineLengthLowerRd <= 1'b0;
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
    for (p = 0; p < 4; p++) begin
      rdc(p, 8'h70, {p[1:0], 6'h2b});
      rdc(p, 8'h71, {p[1:0], 6'h2c});
      rdc(p, 8'h72, 8'he4);
      rdc(p, 8'h74, 8'h00);
      rdc(p, 8'h75, 8'h00);
      rdc(p, 8'h6f, 8'h00);
      wr(p, 8'h70, 8'h90 | 8'(p));
      rdc(p, 8'h70, 8'h90 | 8'(p));
      wr(p, 8'h71, 8'h50 | 8'(p));
      rdc(p, 8'h71, 8'h50 | 8'(p));
      wr(p, 8'h72, 8'h1b);
      wr(p, 8'h73, 8'haa);
      rdc(p, 8'h73, 8'h00);
    end
    for (p = 0; p < 4; p++) begin
      for (c = 0; c < 4; c++) push(p, c);
      #1 check({41'h0, inReady}, 42'h0);
      repeat (4) pop();
    end
    frame(1, 3, 5, 300);
    stats(1, 16'd3, 16'd300);
    rdc(1, 8'h73, 8'h00);
    frame(1, 2, 4, 4);
    rdc(1, 8'h74, 8'h03);
    stats(1, 16'd2, 16'd4);
    rdc(2, 8'h74, 8'h00);
    @(posedge mclk);
    cntEn <= 4'h2;
    lenEn <= 4'h2;
    frame(1, 4, 5, 260);
    frame(1, 6, 5, 5);
    stats(1, 16'd4, 16'd260);
    frame(1, 7, 3, 6);
    stats(1, 16'd7, 16'd6);
    testDone();
  end
endmodule

bind rxvm_port_regs rxvm_port_regs_checker #(.DATA_W(DATA_W)) i_rxvm_port_regs_checker (.mclk(mclk),
  .rst_b(rst_b), .portSelect(portSelect), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData),
  .regRd(regRd), .regRdData(regRdData), .lineLengthLower(lineLengthLower), .inValid(inValid),
  .inReady(inReady), .inPort(inPort), .inData(inData), .outValid(outValid), .outReady(outReady),
  .outPort(outPort), .outChannel(outChannel), .outType(outType), .outData(outData));
`default_nettype wire
